// file: rtl/ddrwc_pkg.sv
package ddrwc_pkg;
	localparam int ADDR_W = 32;
	localparam int LEN_W = 8;
	localparam int STAT_W = 3;
	localparam int REG_AW = 8;
	localparam int DATA_W = 32;
	// register byte offsets
	localparam logic [7:0] OFF_CHECK_CONTROL = 8'h00;
	localparam logic [7:0] OFF_IRQ_RAW_STATUS = 8'h04;
	localparam logic [7:0] OFF_IRQ_ENABLE_SET = 8'h08;
	localparam logic [7:0] OFF_IRQ_ENABLE_CLR = 8'h0c;
	localparam logic [7:0] OFF_RANGE_BASE = 8'h10;
	localparam logic [7:0] OFF_RANGE_LIMIT = 8'h14;
	localparam logic [7:0] OFF_ERROR_ADDR = 8'h18;
	// field positions
	localparam int MERGE_WRITE_ENABLE_BIT = 0;
	localparam int WRITE_CHECK_ERROR_BIT = 0;
	// reset values
	localparam logic [31:0] RANGE_BASE_RST = 32'h0000_0000;
	localparam logic [31:0] RANGE_LIMIT_RST = 32'hffff_ffff;
	// quantum is one 64-bit word: low three address and length bits
	localparam int QUANT_LSB = 3;
	localparam logic [7:0] L2_LINE_BYTES = 8'h80;
	localparam logic [7:0] L1D_LINE_BYTES = 8'h40;
	localparam logic [7:0] BOUND_BYTES = 8'h01;
	// write status codes on the status line
	localparam logic [2:0] WSTAT_OK = 3'h0;
	localparam logic [2:0] WSTAT_SUB_QUANTA = 3'h1;
	// master capture code for a data error
	localparam logic [2:0] BERR_DATA = 3'h4;
	typedef enum logic [2:0] {
		OP_BLOCK_WB = 3'b000,
		OP_BLOCK_WBINV = 3'b001,
		OP_GLOBAL_WB = 3'b010,
		OP_GLOBAL_WBINV = 3'b011,
		OP_DIRECT = 3'b100
	} ddrwc_op_t;
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_ISSUE = 2'b01,
		M_WAIT = 2'b10
	} ddrwc_mst_state_t;
endpackage

// file: rtl/ddrwc_if.sv
`timescale 1ns/1ps
interface ddrwc_if;
	logic wr_valid;
	logic [31:0] wr_addr;
	logic [7:0] wr_bytes;
	logic wr_be_none;
	logic st_valid;
	logic [2:0] st_code;
	modport dev
	(
		input wr_valid,
		input wr_addr,
		input wr_bytes,
		input wr_be_none,
		output st_valid,
		output st_code
	);
	modport mst
	(
		output wr_valid,
		output wr_addr,
		output wr_bytes,
		output wr_be_none,
		input st_valid,
		input st_code
	);
endinterface

// file: rtl/ddrwc_dev.sv
// What this block does
// - aligned whole-word writes in range raise nothing
// - cache writes back whole 128/64 byte lines
// - block writeback ends with enable-less byte
// - no merge: bad write sets raw error bit
// - enable-less write never reaches the memory
// - no merge: sub-quanta write in range returns nonzero status; master logs
// - irq only when enable bit is set; master berr_irq ignores it
// - global writebacks issue no bounding byte
// - master capture holds only the first error
// - merge enable: bad writes merged, no error
// - both flags stay until software clears them
// - one shared error interrupt output
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module ddrwc_dev
	import ddrwc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	ddrwc_if.dev bus,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [7:0] mem_bytes,
	output logic mem_merge
);
	function automatic logic ddrwc_hit(input logic [7:0] a,
		input logic [7:0] off, input logic strobe);
		ddrwc_hit = strobe && (a == off);
	endfunction

	logic merge_en_ff;
	logic nxt_merge_en;
	logic raw_ff;
	logic nxt_raw;
	logic en_ff;
	logic nxt_en;
	logic [31:0] base_ff;
	logic [31:0] nxt_base;
	logic [31:0] limit_ff;
	logic [31:0] nxt_limit;
	logic [31:0] err_addr_ff;
	logic [31:0] nxt_err_addr;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic st_valid_ff;
	logic nxt_st_valid;
	logic [2:0] st_code_ff;
	logic [2:0] nxt_st_code;
	logic mem_we_ff;
	logic nxt_mem_we;
	logic [31:0] mem_addr_ff;
	logic [31:0] nxt_mem_addr;
	logic [7:0] mem_bytes_ff;
	logic [7:0] nxt_mem_bytes;
	logic mem_merge_ff;
	logic nxt_mem_merge;

	logic in_range;
	logic aligned;
	logic violation;
	logic flag_err;
	logic raw_w1c;

	always_comb
	begin
		in_range = (bus.wr_addr >= base_ff) && (bus.wr_addr <= limit_ff);
		// an enable-less byte is never a whole word
		aligned = (bus.wr_addr[QUANT_LSB-1:0] == 3'h0)
			&& (bus.wr_bytes[QUANT_LSB-1:0] == 3'h0)
			&& (bus.wr_bytes != 8'h00) && !bus.wr_be_none;
		violation = bus.wr_valid && in_range && !aligned;
		flag_err = violation && !merge_en_ff;
		raw_w1c = ddrwc_hit(reg_addr, OFF_IRQ_RAW_STATUS, reg_wr)
			&& reg_wdata[WRITE_CHECK_ERROR_BIT];
	end

	always_comb
	begin
		nxt_merge_en = merge_en_ff;
		nxt_en = en_ff;
		nxt_base = base_ff;
		nxt_limit = limit_ff;
		nxt_rdata = 32'h0000_0000;
		if (ddrwc_hit(reg_addr, OFF_CHECK_CONTROL, reg_wr))
		begin
			nxt_merge_en = reg_wdata[MERGE_WRITE_ENABLE_BIT];
		end
		if (ddrwc_hit(reg_addr, OFF_IRQ_ENABLE_SET, reg_wr)
			&& reg_wdata[WRITE_CHECK_ERROR_BIT])
		begin
			nxt_en = 1'b1;
		end
		if (ddrwc_hit(reg_addr, OFF_IRQ_ENABLE_CLR, reg_wr)
			&& reg_wdata[WRITE_CHECK_ERROR_BIT])
		begin
			nxt_en = 1'b0;
		end
		if (ddrwc_hit(reg_addr, OFF_RANGE_BASE, reg_wr))
		begin
			nxt_base = reg_wdata;
		end
		if (ddrwc_hit(reg_addr, OFF_RANGE_LIMIT, reg_wr))
		begin
			nxt_limit = reg_wdata;
		end
		if (reg_rd)
		begin
			case (reg_addr)
				OFF_CHECK_CONTROL:
					nxt_rdata = {31'h0000_0000, merge_en_ff};
				OFF_IRQ_RAW_STATUS:
					nxt_rdata = {31'h0000_0000, raw_ff};
				OFF_IRQ_ENABLE_SET,
				OFF_IRQ_ENABLE_CLR:
					nxt_rdata = {31'h0000_0000, en_ff};
				OFF_RANGE_BASE:
					nxt_rdata = base_ff;
				OFF_RANGE_LIMIT:
					nxt_rdata = limit_ff;
				OFF_ERROR_ADDR:
					nxt_rdata = err_addr_ff;
				default:
					nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_comb
	begin
		// set beats a same-cycle write-one-to-clear
		nxt_raw = (raw_ff && !raw_w1c) || flag_err;
		nxt_err_addr = err_addr_ff;
		// only the first error address is kept until cleared
		if (flag_err && (!raw_ff || raw_w1c))
		begin
			nxt_err_addr = bus.wr_addr;
		end
	end

	always_comb
	begin
		nxt_st_valid = bus.wr_valid;
		nxt_st_code = WSTAT_OK;
		if (flag_err)
		begin
			nxt_st_code = WSTAT_SUB_QUANTA;
		end
		// enable-less writes are dropped: data and check bits untouched
		nxt_mem_we = bus.wr_valid && !bus.wr_be_none;
		nxt_mem_addr = mem_addr_ff;
		nxt_mem_bytes = mem_bytes_ff;
		nxt_mem_merge = 1'b0;
		if (bus.wr_valid && !bus.wr_be_none)
		begin
			nxt_mem_addr = bus.wr_addr;
			nxt_mem_bytes = bus.wr_bytes;
			// without merging the word goes out as is; check bits
			// for partial words are then stale, which is why it flags
			nxt_mem_merge = violation && merge_en_ff;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			merge_en_ff <= 1'b0;
			raw_ff <= 1'b0;
			en_ff <= 1'b0;
			base_ff <= RANGE_BASE_RST;
			limit_ff <= RANGE_LIMIT_RST;
			err_addr_ff <= 32'h0000_0000;
			rdata_ff <= 32'h0000_0000;
			st_valid_ff <= 1'b0;
			st_code_ff <= WSTAT_OK;
			mem_we_ff <= 1'b0;
			mem_addr_ff <= 32'h0000_0000;
			mem_bytes_ff <= 8'h00;
			mem_merge_ff <= 1'b0;
		end
		else
		begin
			merge_en_ff <= nxt_merge_en;
			raw_ff <= nxt_raw;
			en_ff <= nxt_en;
			base_ff <= nxt_base;
			limit_ff <= nxt_limit;
			err_addr_ff <= nxt_err_addr;
			rdata_ff <= nxt_rdata;
			st_valid_ff <= nxt_st_valid;
			st_code_ff <= nxt_st_code;
			mem_we_ff <= nxt_mem_we;
			mem_addr_ff <= nxt_mem_addr;
			mem_bytes_ff <= nxt_mem_bytes;
			mem_merge_ff <= nxt_mem_merge;
		end
	end

	assign bus.st_valid = st_valid_ff;
	assign bus.st_code = st_code_ff;
	assign reg_rdata = rdata_ff;
	// single line for every requester; software sorts out the source
	assign irq = raw_ff && en_ff;
	assign mem_we = mem_we_ff;
	assign mem_addr = mem_addr_ff;
	assign mem_bytes = mem_bytes_ff;
	assign mem_merge = mem_merge_ff;
endmodule

// file: rtl/ddrwc_mst.sv
`timescale 1ns/1ps
module ddrwc_mst
	import ddrwc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	ddrwc_if.mst bus,
	input wire logic op_valid,
	input wire ddrwc_op_t op_kind,
	input wire logic op_level_l2,
	input wire logic [31:0] op_addr,
	input wire logic [7:0] op_lines,
	input wire logic [7:0] op_bytes,
	output logic op_ready,
	input wire logic berr_clear,
	output logic berr_valid,
	output logic [2:0] berr_stat,
	output logic [31:0] berr_addr,
	output logic berr_irq
);
	ddrwc_mst_state_t state_ff, nxt_state;
	logic [31:0] addr_ff, nxt_addr;
	logic [7:0] lines_ff, nxt_lines;
	logic [7:0] step_ff, nxt_step;
	logic [7:0] bytes_ff, nxt_bytes;
	logic bound_ff, nxt_bound;
	logic be_none_ff, nxt_be_none;
	logic bv_ff, nxt_bv;
	logic [2:0] bstat_ff, nxt_bstat;
	logic [31:0] baddr_ff, nxt_baddr;
	logic err_in;
	logic take;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_addr = addr_ff;
		nxt_lines = lines_ff;
		nxt_step = step_ff;
		nxt_bytes = bytes_ff;
		nxt_bound = bound_ff;
		nxt_be_none = be_none_ff;
		case (state_ff)
			M_IDLE:
				if (op_valid)
				begin
					nxt_state = M_ISSUE;
					nxt_addr = op_addr;
					nxt_be_none = 1'b0;
					nxt_lines = (op_lines == 8'h00) ? 8'h01 : op_lines;
					// whole lines only for cache traffic
					nxt_step = op_level_l2 ? L2_LINE_BYTES : L1D_LINE_BYTES;
					nxt_bound = (op_kind == OP_BLOCK_WB)
						|| (op_kind == OP_BLOCK_WBINV);
					if (op_kind == OP_DIRECT)
					begin
						nxt_lines = 8'h01;
						nxt_step = op_bytes;
					end
					nxt_bytes = nxt_step;
				end
			M_ISSUE:
				nxt_state = M_WAIT;
			M_WAIT:
				if (bus.st_valid)
				begin
					nxt_state = M_IDLE;
					if (lines_ff > 8'h01)
					begin
						nxt_state = M_ISSUE;
						nxt_addr = addr_ff + {24'h00_0000, step_ff};
						nxt_lines = lines_ff - 8'h01;
					end
					else if (bound_ff)
					begin
						// last byte of the block, no byte enables
						nxt_state = M_ISSUE;
						nxt_addr = addr_ff + {24'h00_0000, step_ff}
							- 32'h0000_0001;
						nxt_bytes = BOUND_BYTES;
						nxt_be_none = 1'b1;
						nxt_bound = 1'b0;
						nxt_lines = 8'h00;
					end
				end
			default:
				nxt_state = M_IDLE;
		endcase
	end

	always_comb
	begin
		err_in = bus.st_valid && (bus.st_code != WSTAT_OK);
		// a clear in the same cycle lets the new error in
		take = err_in && (!bv_ff || berr_clear);
		nxt_bv = (bv_ff && !berr_clear) || take;
		nxt_bstat = bstat_ff;
		nxt_baddr = baddr_ff;
		if (take)
		begin
			nxt_bstat = BERR_DATA;
			nxt_baddr = addr_ff;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= M_IDLE;
			addr_ff <= 32'h0000_0000;
			lines_ff <= 8'h00;
			step_ff <= 8'h00;
			bytes_ff <= 8'h00;
			bound_ff <= 1'b0;
			be_none_ff <= 1'b0;
			bv_ff <= 1'b0;
			bstat_ff <= 3'h0;
			baddr_ff <= 32'h0000_0000;
		end
		else
		begin
			state_ff <= nxt_state;
			addr_ff <= nxt_addr;
			lines_ff <= nxt_lines;
			step_ff <= nxt_step;
			bytes_ff <= nxt_bytes;
			bound_ff <= nxt_bound;
			be_none_ff <= nxt_be_none;
			bv_ff <= nxt_bv;
			bstat_ff <= nxt_bstat;
			baddr_ff <= nxt_baddr;
		end
	end

	assign bus.wr_valid = (state_ff == M_ISSUE);
	assign bus.wr_addr = addr_ff;
	assign bus.wr_bytes = bytes_ff;
	assign bus.wr_be_none = be_none_ff;
	assign op_ready = (state_ff == M_IDLE);
	assign berr_valid = bv_ff;
	assign berr_stat = bstat_ff;
	assign berr_addr = baddr_ff;
	assign berr_irq = bv_ff;
endmodule

// file: tb/ddrwc_props.sv
`timescale 1ns/1ps
module ddrwc_props
	import ddrwc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wr_valid,
	input wire logic [31:0] wr_addr,
	input wire logic [7:0] wr_bytes,
	input wire logic wr_be_none,
	input wire logic st_valid,
	input wire logic [2:0] st_code
);
	logic [31:0] end_ff;
	logic [31:0] nxt_end;
	logic bad;
	// last byte of the latest real write; the bounding byte must hit it
	always_comb
	begin
		nxt_end = end_ff;
		if (wr_valid && !wr_be_none)
			nxt_end = wr_addr + {24'h00_0000, wr_bytes} - 32'h0000_0001;
	end
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			end_ff <= 32'h0000_0000;
		else
			end_ff <= nxt_end;
	assign bad = wr_addr[2:0] != 3'h0 || wr_bytes[2:0] != 3'h0 ||
		wr_bytes == 8'h00 || wr_be_none;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_status_next: assert property (wr_valid |=> st_valid)
		else $error("no status after write");
	a_no_stray: assert property (st_valid |-> $past(wr_valid))
		else $error("status without write");
	a_req_spacing: assert property (wr_valid |=> !wr_valid)
		else $error("write issued before status");
	a_aligned_clean: assert property (wr_valid && !bad |=> !st_code)
		else $error("error on aligned whole write");
	a_error_cause: assert property (st_valid && st_code |-> $past(bad))
		else $error("error without bad write");
	a_code_legal: assert property (st_valid |-> st_code <= 3'h1)
		else $error("illegal status code");
	a_bound_single: assert property (wr_valid && wr_be_none
		|-> wr_bytes == BOUND_BYTES) else $error("bounding write not one byte");
	a_bound_addr: assert property (wr_valid && wr_be_none
		|-> wr_addr == end_ff) else $error("bounding write misplaced");
	c_bound: cover property (wr_valid && wr_be_none);
	c_err: cover property (st_valid && st_code == WSTAT_SUB_QUANTA);
	c_ok: cover property (st_valid && st_code == WSTAT_OK);
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb
	import ddrwc_pkg::*;
;
	logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, op_valid = 0;
	logic [7:0] reg_addr = 0, op_lines = 0, op_bytes = 0, rd;
	logic [31:0] reg_wdata = 0, op_addr = 0, reg_rdata, berr_addr;
	logic [31:0] mem_cnt = 0, mrg_cnt = 0, ma;
	logic op_level_l2 = 0, berr_clear = 0, irq, mem_we, mem_merge;
	logic op_ready, berr_valid, berr_irq;
	logic [2:0] berr_stat;
	ddrwc_op_t op_kind = OP_DIRECT;
	int err_count = 0, compares = 0, cyc = 0;
	ddrwc_if link();
	ddrwc_dev ddrwc_dev_inst(.core_clk(core_clk), .rst_n(rst_n),
		.bus(link.dev), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.mem_we(mem_we), .mem_addr(ma), .mem_bytes(rd),
		.mem_merge(mem_merge));
	ddrwc_mst ddrwc_mst_inst(.core_clk(core_clk), .rst_n(rst_n),
		.bus(link.mst), .op_valid(op_valid), .op_kind(op_kind),
		.op_level_l2(op_level_l2), .op_addr(op_addr), .op_lines(op_lines),
		.op_bytes(op_bytes), .op_ready(op_ready), .berr_clear(berr_clear),
		.berr_valid(berr_valid), .berr_stat(berr_stat),
		.berr_addr(berr_addr), .berr_irq(berr_irq));
	ddrwc_props ddrwc_props_inst(.core_clk(core_clk), .rst_n(rst_n),
		.wr_valid(link.wr_valid), .wr_addr(link.wr_addr),
		.wr_bytes(link.wr_bytes), .wr_be_none(link.wr_be_none),
		.st_valid(link.st_valid), .st_code(link.st_code));
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		mem_cnt <= mem_cnt + 32'(mem_we);
		mrg_cnt <= mrg_cnt + 32'(mem_merge);
		cyc++;
		if (cyc == 6000)
		begin
			err_count++;
			end_sim();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge core_clk);
		reg_rd <= 0;
		#1 check(reg_rdata, exp);
	endtask
	task automatic op(input ddrwc_op_t k, input logic l2,
		input logic [31:0] a, input logic [7:0] n, input logic [7:0] b);
		int t;
		t = 0;
		@(posedge core_clk);
		op_kind <= k;
		op_level_l2 <= l2;
		op_addr <= a;
		op_lines <= n;
		op_bytes <= b;
		op_valid <= 1;
		@(posedge core_clk);
		op_valid <= 0;
		do
			@(posedge core_clk);
		while (op_ready !== 1'b1 && t++ < 300);
		// a hung operation counts as a mismatch
		check(op_ready, 1'b1);
		repeat (2) @(posedge core_clk);
	endtask
	// clears the raw flag, then the master capture one cycle later
	task automatic clr();
		wr(OFF_IRQ_RAW_STATUS, 32'h0000_0001);
		berr_clear <= 1;
		@(posedge core_clk);
		berr_clear <= 0;
		@(posedge core_clk);
	endtask
	task automatic t_block();
		op(OP_BLOCK_WB, 0, 32'h0000_1000, 8'h01, 8'h00);
		check(mem_cnt, 32'h0000_0001);
		check(ma, 32'h0000_1000);
		check(rd, 8'h40);
		chk(OFF_IRQ_RAW_STATUS, 32'h0000_0001);
		check(irq, 1'b1);
		check({berr_valid, berr_irq, berr_stat}, 5'h1c);
		check(berr_addr, 32'h0000_103f);
		chk(OFF_ERROR_ADDR, 32'h0000_103f);
	endtask
	task automatic t_capture();
		op(OP_DIRECT, 0, 32'h0000_3004, 8'h01, 8'h04);
		check(berr_addr, 32'h0000_103f);
		clr();
		chk(OFF_IRQ_RAW_STATUS, 32'h0000_0000);
		check({irq, berr_valid}, 2'h0);
		op(OP_DIRECT, 0, 32'h0000_3004, 8'h01, 8'h04);
		check(berr_addr, 32'h0000_3004);
		chk(OFF_IRQ_RAW_STATUS, 32'h0000_0001);
		clr();
	endtask
	task automatic t_global();
		op(OP_GLOBAL_WBINV, 1, 32'h0000_4000, 8'h02, 8'h00);
		op(OP_GLOBAL_WB, 0, 32'h0000_5000, 8'h00, 8'h00);
		check(mem_cnt, 32'h0000_0006);
		chk(OFF_IRQ_RAW_STATUS, 32'h0000_0000);
		check(berr_valid, 1'b0);
	endtask
	task automatic t_mask();
		wr(OFF_IRQ_ENABLE_CLR, 32'h0000_0001);
		op(OP_BLOCK_WBINV, 1, 32'h0000_6000, 8'h02, 8'h00);
		chk(OFF_IRQ_RAW_STATUS, 32'h0000_0001);
		check(irq, 1'b0);
		wr(OFF_IRQ_ENABLE_SET, 32'h0000_0001);
		#1 check(irq, 1'b1);
		clr();
	endtask
	// only the protected window is checked; limit is inclusive
	task automatic t_range();
		wr(OFF_RANGE_BASE, 32'h0000_8000);
		wr(OFF_RANGE_LIMIT, 32'h0000_8fff);
		chk(OFF_RANGE_BASE, 32'h0000_8000);
		op(OP_DIRECT, 0, 32'h0000_9000, 8'h01, 8'h01);
		chk(OFF_IRQ_RAW_STATUS, 32'h0000_0000);
		check(berr_valid, 1'b0);
		op(OP_DIRECT, 0, 32'h0000_8fff, 8'h01, 8'h01);
		chk(OFF_ERROR_ADDR, 32'h0000_8fff);
		check(berr_addr, 32'h0000_8fff);
		wr(OFF_RANGE_BASE, RANGE_BASE_RST);
		wr(OFF_RANGE_LIMIT, RANGE_LIMIT_RST);
		clr();
	endtask
	task automatic t_merge();
		wr(OFF_CHECK_CONTROL, 32'h0000_0001);
		op(OP_BLOCK_WB, 1, 32'h0000_7000, 8'h01, 8'h00);
		op(OP_DIRECT, 0, 32'h0000_7003, 8'h01, 8'h05);
		check(mem_cnt, 32'h0000_000c);
		check(mrg_cnt, 32'h0000_0001);
		chk(OFF_IRQ_RAW_STATUS, 32'h0000_0000);
		check(berr_valid, 1'b0);
	endtask
	task automatic end_sim();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1;
		chk(OFF_CHECK_CONTROL, 32'h0000_0000);
		chk(OFF_RANGE_LIMIT, RANGE_LIMIT_RST);
		chk(8'h40, 32'h0000_0000);
		wr(OFF_IRQ_ENABLE_SET, 32'h0000_0001);
		t_block();
		t_capture();
		t_global();
		t_mask();
		t_range();
		t_merge();
		end_sim();
	end
endmodule
